/* common/frs_pkg.sv */
package frs_pkg;
  localparam logic [7:0] ADDR_PKT_STATUS = 8'h03;
  localparam logic [7:0] ADDR_LINK_CODE  = 8'h04;
  // packet status bit positions
  localparam int BIT_ABORT   = 7;
  localparam int BIT_CRC_ERR = 6;
  localparam int BIT_OVERRUN = 5;
  localparam int BIT_VALID   = 4;
  localparam int BIT_EMPTY   = 3;
  localparam int BIT_PKT_OK  = 2;
  localparam int BIT_CLOSING = 1;
  localparam int BIT_OPENING = 0;
  // link code bit positions
  localparam int BIT_CODE_LATCHED = 7;
  localparam int BIT_CODE_LIVE    = 6;
  localparam int CODE_W           = 6;
  localparam logic [5:0] CODE_RESET = 6'h3F;
  localparam int FIFO_DEPTH = 16;
  localparam int HALF_LEVEL = 8;
  localparam logic [2:0] ABORT_ONES = 3'h7;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // one byte delivered by the receive HDLC controller
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       first;
    logic       last;
    logic       crc_bad;
  } frs_rx_byte_t;

  // one FIFO entry: head-of-FIFO markers travel with the byte
  typedef struct packed {
    logic       pkt_ok;
    logic       closing;
    logic       opening;
    logic [7:0] data;
  } frs_fifo_word_t;

  // code detector output
  typedef struct packed {
    logic       valid;
    logic [5:0] code;
  } frs_code_t;
endpackage

/* hdl/frs_rx_fifo.sv */
`timescale 1ns/100ps
module frs_rx_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16,
  parameter int LW    = $clog2(DEPTH + 1)
) (
  input  wire logic             mclk_i,
  input  wire logic             resetn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o,
  output logic      [LW-1:0]    level_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr_r;
  logic [AW-1:0]    rptr_r;
  logic [LW-1:0]    level_r;
  wire              push = in_valid_i && in_ready_o;
  wire              pop  = out_valid_o && out_ready_i;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready_o  = (level_r != LW'(DEPTH));
  assign out_valid_o = (level_r != '0);
  assign out_data_o  = mem[rptr_r];
  assign level_o     = level_r;

  always_ff @(posedge mclk_i)
  begin
    if (push)
      mem[wptr_r] <= in_data_i;
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wptr_r  <= '0;
      rptr_r  <= '0;
      level_r <= '0;
    end
    else
    begin
      if (push)
        wptr_r <= bump(wptr_r);
      if (pop)
        rptr_r <= bump(rptr_r);
      level_r <= level_r + LW'(push) - LW'(pop);
    end
  end

  a_fifo_no_overfill: assert property (@(posedge mclk_i)
    disable iff (!resetn_i) level_r <= LW'(DEPTH))
    else $error("fifo level above depth");
endmodule // frs_rx_fifo

/* hdl/frs_status.sv */
`timescale 1ns/100ps
module frs_status #(
  parameter int DEPTH = frs_pkg::FIFO_DEPTH,
  parameter int HALF  = frs_pkg::HALF_LEVEL
) (
  input  wire logic                 mclk_i,
  input  wire logic                 resetn_i,
  // host read port
  input  wire logic                 rd_i,
  input  wire logic [7:0]           addr_i,
  output logic      [7:0]           rdata_o,
  // serial link bits seen by the receive controller
  input  wire logic                 link_bit_en_i,
  input  wire logic                 link_bit_i,
  // bytes from the receive controller
  input  wire frs_pkg::frs_rx_byte_t rx_byte_i,
  // code detector
  input  wire frs_pkg::frs_code_t   code_i,
  // FIFO drain side
  input  wire logic                 pop_i,
  output logic      [7:0]           head_data_o,
  output logic                      head_valid_o,
  output logic                      rx_ready_o,
  // summary outputs
  output logic                      rx_half_o,
  output logic                      packet_end_summary_o,
  output logic                      code_change_o
);
  localparam int LW = $clog2(DEPTH + 1);

  // sticky flags
  logic       abort_seen_flag_r;
  logic       checksum_error_flag_r;
  logic       rx_overrun_flag_r;
  logic       valid_message_flag_r;
  logic       abort_seen_flag_nxt;
  logic       checksum_error_flag_nxt;
  logic       rx_overrun_flag_nxt;
  logic       valid_message_flag_nxt;
  // per-message fault memory
  logic       msg_abort_r;
  logic       msg_ovr_r;
  logic [2:0] ones_cnt_r;
  // code side
  logic [5:0] link_code_r;
  logic       code_detected_live_r;
  logic       code_detected_latched_r;
  logic       code_detected_latched_nxt;
  // output flops
  logic [7:0] rdata_r;
  logic [7:0] head_data_r;
  logic       head_valid_r;
  logic       rx_ready_r;
  logic       rx_half_r;
  logic       pkt_end_r;
  logic       code_change_r;

  // FIFO wiring
  frs_pkg::frs_fifo_word_t in_word;
  frs_pkg::frs_fifo_word_t head_word;
  logic                    fifo_in_ready;
  logic                    fifo_out_valid;
  logic [LW-1:0]           fifo_level;

  // read decode
  wire rd_status = rd_i && (addr_i == frs_pkg::ADDR_PKT_STATUS);
  wire rd_code   = rd_i && (addr_i == frs_pkg::ADDR_LINK_CODE);

  // abort: a one that brings the run to seven
  wire abort_evt = link_bit_en_i && link_bit_i &&
                   (ones_cnt_r == frs_pkg::ABORT_ONES - 3'h1);
  wire byte_push = rx_byte_i.valid;
  wire ovr_evt   = byte_push && !fifo_in_ready;
  wire accepted  = byte_push && fifo_in_ready;
  // faults seen so far in this message, including this byte
  wire msg_abort = msg_abort_r || abort_evt;
  wire msg_ovr   = msg_ovr_r || ovr_evt;
  wire last_in   = byte_push && rx_byte_i.last;
  wire crc_evt   = last_in && rx_byte_i.crc_bad;
  wire valid_evt = last_in && !rx_byte_i.crc_bad &&
                   !msg_abort && !msg_ovr;

  assign in_word.data    = rx_byte_i.data;
  assign in_word.opening = rx_byte_i.first;
  assign in_word.closing = rx_byte_i.last;
  assign in_word.pkt_ok  = valid_evt;

  frs_rx_fifo #(
    .WIDTH ($bits(frs_pkg::frs_fifo_word_t)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (byte_push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (in_word),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (pop_i),
    .out_data_o  (head_word),
    .level_o     (fifo_level)
  );

  // set wins over read clear
  assign abort_seen_flag_nxt     = abort_evt ||
                                   (abort_seen_flag_r && !rd_status);
  assign checksum_error_flag_nxt = crc_evt ||
                                   (checksum_error_flag_r && !rd_status);
  assign rx_overrun_flag_nxt     = ovr_evt ||
                                   (rx_overrun_flag_r && !rd_status);
  assign valid_message_flag_nxt  = valid_evt ||
                                   (valid_message_flag_r && !rd_status);
  assign code_detected_latched_nxt = code_detected_live_r ||
                     (code_detected_latched_r && !rd_code);

  // status byte as it stands this cycle
  wire [7:0] status_byte = {abort_seen_flag_r,
                            checksum_error_flag_r,
                            rx_overrun_flag_r,
                            valid_message_flag_r,
                            !fifo_out_valid,
                            fifo_out_valid && head_word.pkt_ok,
                            fifo_out_valid && head_word.closing,
                            fifo_out_valid && head_word.opening};
  wire [7:0] code_byte = {code_detected_latched_r,
                          code_detected_live_r,
                          link_code_r};
  wire [7:0] rdata_nxt = rd_status ? status_byte :
                         rd_code   ? code_byte   : rdata_r;

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      abort_seen_flag_r     <= 1'b0;
      checksum_error_flag_r <= 1'b0;
      rx_overrun_flag_r     <= 1'b0;
      valid_message_flag_r  <= 1'b0;
    end
    else
    begin
      abort_seen_flag_r     <= abort_seen_flag_nxt;
      checksum_error_flag_r <= checksum_error_flag_nxt;
      rx_overrun_flag_r     <= rx_overrun_flag_nxt;
      valid_message_flag_r  <= valid_message_flag_nxt;
    end
  end

  // run length of ones and faults of the current message
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ones_cnt_r  <= 3'h0;
      msg_abort_r <= 1'b0;
      msg_ovr_r   <= 1'b0;
    end
    else
    begin
      if (link_bit_en_i)
        ones_cnt_r <= !link_bit_i ? 3'h0 :
                      (ones_cnt_r == frs_pkg::ABORT_ONES) ? ones_cnt_r :
                      ones_cnt_r + 3'h1;
      if (last_in)
      begin
        msg_abort_r <= 1'b0;
        msg_ovr_r   <= 1'b0;
      end
      else
      begin
        msg_abort_r <= msg_abort;
        msg_ovr_r   <= msg_ovr;
      end
    end
  end

  // code register
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      link_code_r             <= frs_pkg::CODE_RESET;
      code_detected_live_r    <= 1'b0;
      code_detected_latched_r <= 1'b0;
    end
    else
    begin
      if (code_i.valid)
        link_code_r <= code_i.code;
      code_detected_live_r    <= code_i.valid;
      code_detected_latched_r <= code_detected_latched_nxt;
    end
  end

  // output flops
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rdata_r       <= frs_pkg::RDATA_RESET;
      head_data_r   <= 8'h00;
      head_valid_r  <= 1'b0;
      rx_ready_r    <= 1'b0;
      rx_half_r     <= 1'b0;
      pkt_end_r     <= 1'b0;
      code_change_r <= 1'b0;
    end
    else
    begin
      rdata_r       <= rdata_nxt;
      head_data_r   <= head_word.data;
      head_valid_r  <= fifo_out_valid;
      rx_ready_r    <= fifo_in_ready;
      rx_half_r     <= (fifo_level > LW'(HALF));
      pkt_end_r     <= valid_evt || crc_evt || ovr_evt || abort_evt;
      code_change_r <= (code_i.valid != code_detected_live_r);
    end
  end

  assign rdata_o              = rdata_r;
  assign head_data_o          = head_data_r;
  assign head_valid_o         = head_valid_r;
  assign rx_ready_o           = rx_ready_r;
  assign rx_half_o            = rx_half_r;
  assign packet_end_summary_o = pkt_end_r;
  assign code_change_o        = code_change_r;

  a_status_read_map: assert property (@(posedge mclk_i)
    disable iff (!resetn_i) rd_status |=> rdata_o == $past(status_byte))
    else $error("status read returned wrong byte");

  a_abort_on_seven: assert property (@(posedge mclk_i)
    disable iff (!resetn_i)
    (link_bit_en_i && link_bit_i && ones_cnt_r == 3'h6)
    |=> abort_seen_flag_r)
    else $error("abort flag missed after seven ones");

  a_crc_sets_flag: assert property (@(posedge mclk_i)
    disable iff (!resetn_i) crc_evt |=> checksum_error_flag_r)
    else $error("checksum flag not set");

  a_overrun_sets: assert property (@(posedge mclk_i)
    disable iff (!resetn_i)
    (byte_push && fifo_level == LW'(DEPTH)) |=> rx_overrun_flag_r)
    else $error("overrun flag not set on full push");

  a_valid_sets: assert property (@(posedge mclk_i)
    disable iff (!resetn_i) valid_evt |=> valid_message_flag_r)
    else $error("valid message flag not set");

  a_empty_live: assert property (@(posedge mclk_i)
    disable iff (!resetn_i) status_byte[frs_pkg::BIT_EMPTY]
    == (fifo_level == '0))
    else $error("empty bit disagrees with level");

  a_flag_read_clear: assert property (@(posedge mclk_i)
    disable iff (!resetn_i)
    (rd_status && !abort_evt) |=> !abort_seen_flag_r)
    else $error("abort flag not cleared by read");

  a_crc_read_clear: assert property (@(posedge mclk_i)
    disable iff (!resetn_i)
    (rd_status && !crc_evt) |=> !checksum_error_flag_r)
    else $error("checksum flag not cleared by read");

  a_flag_sticky: assert property (@(posedge mclk_i)
    disable iff (!resetn_i)
    (valid_message_flag_r && !rd_status) |=> valid_message_flag_r)
    else $error("valid flag dropped without read");

  a_latched_follows: assert property (@(posedge mclk_i)
    disable iff (!resetn_i)
    code_i.valid |=> ##1 code_detected_latched_r)
    else $error("latched detect missed live state");

  a_latched_clear: assert property (@(posedge mclk_i)
    disable iff (!resetn_i)
    (rd_code && !code_detected_live_r) |=> !code_detected_latched_r)
    else $error("latched detect not cleared by read");

  a_code_holds: assert property (@(posedge mclk_i)
    disable iff (!resetn_i)
    !code_i.valid |=> $stable(link_code_r))
    else $error("code field changed without valid code");

  a_code_loads: assert property (@(posedge mclk_i)
    disable iff (!resetn_i)
    code_i.valid |=> link_code_r == $past(code_i.code))
    else $error("code field missed a valid code");

  a_change_pulse: assert property (@(posedge mclk_i)
    disable iff (!resetn_i)
    code_change_o == $changed(code_detected_live_r))
    else $error("change pulse disagrees with detect change");

  a_half_level: assert property (@(posedge mclk_i)
    disable iff (!resetn_i)
    (fifo_level > LW'(HALF)) |=> rx_half_o)
    else $error("half flag missing above halfway");

  a_push_fills: assert property (@(posedge mclk_i)
    disable iff (!resetn_i)
    (accepted && !pop_i) |=> fifo_level == $past(fifo_level) + LW'(1))
    else $error("accepted byte did not raise fifo level");

  a_ready_full: assert property (@(posedge mclk_i)
    disable iff (!resetn_i)
    (fifo_level == LW'(DEPTH)) |=> !rx_ready_o)
    else $error("ready shown while fifo full");

  a_end_summary: assert property (@(posedge mclk_i)
    disable iff (!resetn_i)
    (crc_evt || ovr_evt || valid_evt || abort_evt) |=> packet_end_summary_o)
    else $error("packet end pulse missing");
endmodule // frs_status

/* testbench/frs_host_model.sv */
`timescale 1ns/100ps
module frs_host_model (
  input  wire logic       mclk_i,
  input  wire logic [7:0] rdata_i,
  output logic            rd_o,
  output logic      [7:0] addr_o,
  output logic            pop_o
);
  initial
  begin
    rd_o   = 1'b0;
    addr_o = 8'h00;
    pop_o  = 1'b0;
  end

  // one-cycle strobe, data taken just after the edge that samples it
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    rd_o   <= 1'b1;
    addr_o <= a;
    @(posedge mclk_i);
    rd_o <= 1'b0;
    #1;
    d = rdata_i;
  endtask

  // head markers are read before the byte is removed
  task automatic pop_byte();
    logic [7:0] d;
    read_reg(frs_pkg::ADDR_PKT_STATUS, d);
    @(posedge mclk_i);
    pop_o <= 1'b1;
    @(posedge mclk_i);
    pop_o <= 1'b0;
  endtask
endmodule // frs_host_model

/* testbench/testbench.sv */
`timescale 1ns/100ps
module testbench;
  typedef struct packed {
    logic [7:0] ones;
    logic [7:0] exp;
  } frs_tb_row_t;

  logic                  mclk_i   = 1'b0;
  logic                  resetn_i = 1'b0;
  logic                  rd, pop, half, ready, hvalid, pkt_end, code_chg;
  logic                  link_en  = 1'b0;
  logic                  link_bit = 1'b0;
  logic [7:0]            addr, rdata, hdata, got;
  frs_pkg::frs_rx_byte_t rx_byte  = '0;
  frs_pkg::frs_code_t    code     = '0;
  int                    n_mismatch = 0;
  int                    tests_run  = 0;
  int                    cycles     = 0;
  int                    n_end      = 0;
  int                    n_chg      = 0;
  int                    e0;
  frs_tb_row_t           rows [4] = '{'{8'h06, 8'h08}, '{8'h07, 8'h88},
                                      '{8'h03, 8'h08}, '{8'h09, 8'h88}};

  frs_status frs_status_i (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .rd_i(rd), .addr_i(addr),
    .rdata_o(rdata), .link_bit_en_i(link_en), .link_bit_i(link_bit),
    .rx_byte_i(rx_byte), .code_i(code), .pop_i(pop),
    .head_data_o(hdata), .head_valid_o(hvalid), .rx_ready_o(ready),
    .rx_half_o(half), .packet_end_summary_o(pkt_end),
    .code_change_o(code_chg)
  );

  frs_host_model frs_host_model_i (
    .mclk_i(mclk_i), .rdata_i(rdata), .rd_o(rd), .addr_o(addr), .pop_o(pop)
  );

  always #25 mclk_i = ~mclk_i;

  // pulse counters and run ceiling
  always @(posedge mclk_i)
  begin
    cycles++;
    if (pkt_end === 1'b1)
      n_end++;
    if (code_chg === 1'b1)
      n_chg++;
    if (cycles == 4000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("TB: %0d checks, %0d mismatches", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] seen);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a,
                        input logic [7:0] exp);
    frs_host_model_i.read_reg(a, got);
    chk(name, exp, got);
  endtask

  task automatic push(input logic f, input logic l, input logic c,
                      input logic [7:0] d);
    @(posedge mclk_i);
    rx_byte <= {1'b1, d, f, l, c};
    @(posedge mclk_i);
    rx_byte <= '0;
  endtask

  // n ones then a zero on the link
  task automatic link_bits(input int n);
    @(posedge mclk_i);
    link_en  <= 1'b1;
    link_bit <= 1'b1;
    repeat (n) @(posedge mclk_i);
    link_bit <= 1'b0;
    @(posedge mclk_i);
    link_en <= 1'b0;
  endtask

  task automatic set_code(input logic v, input logic [5:0] c);
    @(posedge mclk_i);
    code <= {v, c};
    repeat (3) @(posedge mclk_i);
  endtask

  initial
  begin
    repeat (4) @(posedge mclk_i);
    resetn_i <= 1'b1;
    rd_chk("code reset", 8'h04, 8'h3F);
    rd_chk("status idle", 8'h03, 8'h08);
    chk("ready idle", 8'h01, 8'(ready));
    e0 = n_end;
    push(1'b1, 1'b0, 1'b0, 8'hA5);
    push(1'b0, 1'b1, 1'b0, 8'h5A);
    repeat (2) @(posedge mclk_i);
    chk("end pulse", 8'h01, 8'(n_end - e0));
    rd_chk("status open", 8'h03, 8'h11);
    chk("head data", 8'hA5, hdata);
    chk("head valid", 8'h01, 8'(hvalid));
    rd_chk("status clear", 8'h03, 8'h01);
    frs_host_model_i.pop_byte();
    rd_chk("status close", 8'h03, 8'h06);
    frs_host_model_i.pop_byte();
    rd_chk("status empty", 8'h03, 8'h08);
    push(1'b1, 1'b1, 1'b1, 8'h3C);
    rd_chk("status crc", 8'h03, 8'h43);
    frs_host_model_i.pop_byte();
    foreach (rows[i])
    begin
      e0 = n_end;
      link_bits(rows[i].ones);
      rd_chk("abort status", 8'h03, rows[i].exp);
      chk("abort pulse", 8'(rows[i].exp[7]), 8'(n_end - e0));
    end
    e0 = n_end;
    for (int i = 0; i < 17; i++)
    begin
      push(i == 0, 1'b0, 1'b0, 8'(i));
      if (i == 7 || i == 8)
      begin
        @(posedge mclk_i);
        #1;
        chk("half", 8'(i == 8), 8'(half));
      end
    end
    repeat (2) @(posedge mclk_i);
    chk("ready full", 8'h00, 8'(ready));
    chk("overrun pulse", 8'h01, 8'(n_end - e0));
    rd_chk("status overrun", 8'h03, 8'h21);
    repeat (16) frs_host_model_i.pop_byte();
    repeat (2) @(posedge mclk_i);
    chk("head valid", 8'h00, 8'(hvalid));
    rd_chk("status drained", 8'h03, 8'h08);
    e0 = n_chg;
    set_code(1'b1, 6'h2A);
    set_code(1'b0, 6'h00);
    rd_chk("code held", 8'h04, 8'hAA);
    rd_chk("code latch clr", 8'h04, 8'h2A);
    set_code(1'b1, 6'h15);
    rd_chk("code live", 8'h04, 8'hD5);
    set_code(1'b0, 6'h00);
    chk("change pulses", 8'h04, 8'(n_chg - e0));
    frs_host_model_i.read_reg(8'h05, got);
    chk("unmapped", 8'hD5, got);
    @(posedge mclk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
    chk("reset rdata", 8'h00, rdata);
    chk("reset ready", 8'h00, 8'(ready));
    chk("reset half", 8'h00, 8'(half));
    chk("reset hvalid", 8'h00, 8'(hvalid));
    @(posedge mclk_i);
    resetn_i <= 1'b1;
    rd_chk("code rereset", 8'h04, 8'h3F);
    finish_test();
  end
endmodule // testbench
